// *** hw/sawm_pkg.sv ***
package sawm_pkg;
  localparam int NUM_AXES = 2;
  localparam int PARAM_W  = 16;

  // Display codes, alarms first in ascending order
  localparam logic [7:0] CODE_NONE           = 8'h00;
  localparam logic [7:0] CODE_OVERLOAD_ONE   = 8'h50;
  localparam logic [7:0] CODE_IMPACT_TWO     = 8'h5a;
  localparam logic [7:0] CODE_SUPPLY_ERR     = 8'h60;
  localparam logic [7:0] CODE_SUPPLY_LINK    = 8'h82;
  localparam logic [7:0] CODE_SW_TIMEOUT     = 8'h88;
  localparam logic [7:0] CODE_SCALE_STARTUP  = 8'h90;
  localparam logic [7:0] CODE_FRAME_RECV     = 8'h91;
  localparam logic [7:0] CODE_FRAME_FORMAT   = 8'h92;
  localparam logic [7:0] CODE_POS_UNSTABLE   = 8'h93;
  localparam logic [7:0] CODE_SCALE_DEVIATE  = 8'h96;
  localparam logic [7:0] CODE_SCALE_OFFSET   = 8'h97;
  localparam logic [7:0] CODE_TURN_COUNTER   = 8'h9e;
  localparam logic [7:0] CODE_CELL_LOW       = 8'h9f;
  localparam logic [7:0] CODE_OVERLOAD_PRE   = 8'he1;
  localparam logic [7:0] CODE_POS_INVALID    = 8'he3;
  localparam logic [7:0] CODE_SETTING_REJECT = 8'he4;
  localparam logic [7:0] CODE_AXIS_DETACH    = 8'he6;
  localparam logic [7:0] CODE_HOST_ESTOP     = 8'he7;
  localparam logic [7:0] CODE_SUPPLY_WARN    = 8'he8;

  localparam logic [6:0] PRE_WARN_PCT   = 7'h50;  // 80 percent
  localparam logic [7:0] LOAD_RESET_PCT = 8'h32;  // 50 percent
  localparam logic [PARAM_W-1:0] PARAM_RESET = 16'h0000;

  typedef struct packed {
    logic                powerOn;
    logic                reset;
    logic                estop;
    logic                ready;
    logic [NUM_AXES-1:0] servoOn;
    logic [NUM_AXES-1:0] detach;
  } sawm_host_s;

  typedef struct packed {
    logic impactTwo;
    logic overloadTrip;
    logic scaleStartFail;
    logic frameRecvBad;
    logic frameFormatBad;
    logic posUnstable;
    logic scaleDeviation;
    logic scaleOffsetBad;
    logic turnCounterBad;
    logic cellLow;
    logic posCounterInvalid;
  } sawm_axis_fault_s;

  typedef struct packed {
    logic       supplyLinkLoss;
    logic       softwareTimeout;
    logic       supplyErrValid;
    logic [4:0] supplyErrIdx;
    logic       supplyWarnValid;
    logic [1:0] supplyWarnIdx;
  } sawm_shared_fault_s;
endpackage

// *** hw/sawm_alarm_manager.sv ***
module sawm_alarm_manager
  import sawm_pkg::*;
#(
  parameter int PW = PARAM_W
) (
  input  wire logic                          clk,
  input  wire logic                          clkEn,
  input  wire logic                          sys_rst,
  input  wire sawm_pkg::sawm_host_s          hostPins,
  input  wire sawm_pkg::sawm_axis_fault_s    axisFaults [sawm_pkg::NUM_AXES],
  input  wire sawm_pkg::sawm_shared_fault_s  sharedFaults,
  input  wire logic [15:0]                   olAccum,
  input  wire logic [15:0]                   olTripLevel,
  input  wire logic [7:0]                    loadMonPct,
  input  wire logic                          paramWrEn,
  input  wire logic                          paramWrAxis,
  input  wire logic [PW-1:0]                 paramWrData,
  input  wire logic [PW-1:0]                 paramMin,
  input  wire logic [PW-1:0]                 paramMax,
  output logic [7:0]                         displayCode [sawm_pkg::NUM_AXES],
  output logic [sawm_pkg::NUM_AXES-1:0]      alarmActive,
  output logic [sawm_pkg::NUM_AXES-1:0]      servoOffCmd,
  output logic [sawm_pkg::NUM_AXES-1:0]      absLoadBlock,
  output logic [sawm_pkg::NUM_AXES-1:0]      absInitReq,
  output logic [PW-1:0]                      paramValue [sawm_pkg::NUM_AXES],
  output logic                               phaseDrivePowerOn
);
  import sawm_pkg::*;

  function automatic logic atLeastPct(input logic [15:0] val,
                                      input logic [15:0] lim,
                                      input logic [6:0]  pct);
    atLeastPct = ({8'h00, val} * 24'd100) >= ({8'h00, lim} * {17'h0, pct});
  endfunction

  sawm_host_s hostSync1_reg;
  sawm_host_s hostSync2_reg;
  sawm_host_s hostPrev_reg;
  logic                powerDown;
  logic                resetEdge;
  logic                phHost;
  logic [NUM_AXES-1:0] phServo;
  logic [NUM_AXES-1:0] phDetach;
  logic                anyPhase;
  logic                overloadPre;
  logic                loadLow;
  logic [NUM_AXES-1:0] impact_reg;
  logic [NUM_AXES-1:0] overload_reg;
  logic [NUM_AXES-1:0] scaleStart_reg;
  logic [NUM_AXES-1:0] posUnstable_reg;
  logic [NUM_AXES-1:0] scaleOffset_reg;
  logic [NUM_AXES-1:0] reject_reg;
  logic                linkLoss_reg;
  logic                swTimeout_reg;
  logic [7:0]          code_next [NUM_AXES];
  logic [NUM_AXES-1:0] alarm_next;
  logic [NUM_AXES-1:0] posInvalid_next;

  // Host pins are asynchronous to the drive clock
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hostSync1_reg <= '0;
      hostSync2_reg <= '0;
      hostPrev_reg  <= '0;
    end else if (clkEn) begin
      hostSync1_reg <= hostPins;
      hostSync2_reg <= hostSync1_reg;
      hostPrev_reg  <= hostSync2_reg;
    end
  end

  assign powerDown = hostPrev_reg.powerOn & ~hostSync2_reg.powerOn;
  assign resetEdge = hostSync2_reg.reset & ~hostPrev_reg.reset;

  // First phase lasts from drive power-up until the host comes up
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      phaseDrivePowerOn <= 1'b1;
    end else if (clkEn && hostSync2_reg.powerOn) begin
      phaseDrivePowerOn <= 1'b0;
    end
  end

  always_comb begin
    phHost   = hostSync2_reg.powerOn & hostSync2_reg.estop;
    phServo  = {NUM_AXES{hostSync2_reg.powerOn & ~hostSync2_reg.estop}}
               & hostSync2_reg.servoOn;
    phDetach = {NUM_AXES{hostSync2_reg.powerOn & hostSync2_reg.ready}}
               & hostSync2_reg.detach & ~hostSync2_reg.servoOn;
    anyPhase = phHost | (|phServo) | (|phDetach);
  end

  assign overloadPre = atLeastPct(olAccum, olTripLevel, PRE_WARN_PCT);
  assign loadLow     = loadMonPct < LOAD_RESET_PCT;

  // Latched per-axis faults; a set in the clearing cycle wins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      impact_reg      <= '0;
      overload_reg    <= '0;
      scaleStart_reg  <= '0;
      posUnstable_reg <= '0;
      scaleOffset_reg <= '0;
    end else if (clkEn) begin
      for (int a = 0; a < NUM_AXES; a++) begin
        impact_reg[a] <= (axisFaults[a].impactTwo & phServo[a])
                         | (impact_reg[a] & ~resetEdge & ~powerDown);
        overload_reg[a] <= (axisFaults[a].overloadTrip
                            & (phHost | phServo[a] | phDetach[a]))
                           | (overload_reg[a] & ~powerDown
                              & ~(resetEdge & loadLow));
        scaleStart_reg[a] <= (axisFaults[a].scaleStartFail & phHost)
                             | (scaleStart_reg[a] & ~powerDown);
        posUnstable_reg[a] <= (axisFaults[a].posUnstable
                               & (phHost | phServo[a]))
                              | (posUnstable_reg[a] & ~powerDown);
        scaleOffset_reg[a] <= (axisFaults[a].scaleOffsetBad & phHost)
                              | (scaleOffset_reg[a] & ~powerDown);
      end
    end
  end

  // Shared faults count for both axes
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      linkLoss_reg  <= 1'b0;
      swTimeout_reg <= 1'b0;
    end else if (clkEn) begin
      linkLoss_reg <= (sharedFaults.supplyLinkLoss & anyPhase)
                      | (linkLoss_reg & ~powerDown);
      // Only a drive power cycle, i.e. sys_rst, releases this one
      if (sharedFaults.softwareTimeout & (phaseDrivePowerOn | anyPhase)) begin
        swTimeout_reg <= 1'b1;
      end
    end
  end

  // Stored settings; a bad value never reaches the store
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reject_reg <= '0;
      for (int a = 0; a < NUM_AXES; a++) begin
        paramValue[a] <= PARAM_RESET;
      end
    end else if (clkEn && paramWrEn) begin
      for (int a = 0; a < NUM_AXES; a++) begin
        if (paramWrAxis == a[0]) begin
          if (paramWrData < paramMin || paramWrData > paramMax) begin
            reject_reg[a] <= phHost | phServo[a];
          end else begin
            paramValue[a] <= paramWrData;
            reject_reg[a] <= 1'b0;
          end
        end
      end
    end
  end

  // Alarms outrank warnings, then statuses; lowest code first
  always_comb begin
    for (int a = 0; a < NUM_AXES; a++) begin
      code_next[a]  = CODE_NONE;
      alarm_next[a] = 1'b1;
      posInvalid_next[a] = axisFaults[a].posCounterInvalid
                           & (phHost | phServo[a]);
      if (overload_reg[a]) begin
        code_next[a] = CODE_OVERLOAD_ONE;
      end else if (impact_reg[a]) begin
        code_next[a] = CODE_IMPACT_TWO;
      end else if (sharedFaults.supplyErrValid) begin
        code_next[a] = CODE_SUPPLY_ERR
                       | {3'b000, sharedFaults.supplyErrIdx};
      end else if (linkLoss_reg) begin
        code_next[a] = CODE_SUPPLY_LINK;
      end else if (swTimeout_reg) begin
        code_next[a] = CODE_SW_TIMEOUT;
      end else begin
        alarm_next[a] = 1'b0;
        if (scaleStart_reg[a]) begin
          code_next[a] = CODE_SCALE_STARTUP;
        end else if (axisFaults[a].frameRecvBad
                     & (phHost | phServo[a])) begin
          code_next[a] = CODE_FRAME_RECV;
        end else if (axisFaults[a].frameFormatBad
                     & (phHost | phServo[a])) begin
          code_next[a] = CODE_FRAME_FORMAT;
        end else if (posUnstable_reg[a]) begin
          code_next[a] = CODE_POS_UNSTABLE;
        end else if (axisFaults[a].scaleDeviation
                     & (phHost | phServo[a] | phDetach[a])) begin
          code_next[a] = CODE_SCALE_DEVIATE;
        end else if (scaleOffset_reg[a]) begin
          code_next[a] = CODE_SCALE_OFFSET;
        end else if (axisFaults[a].turnCounterBad
                     & (phHost | phServo[a] | phDetach[a])) begin
          code_next[a] = CODE_TURN_COUNTER;
        end else if (axisFaults[a].cellLow
                     & (phHost | phServo[a] | phDetach[a])) begin
          code_next[a] = CODE_CELL_LOW;
        end else if (overloadPre & anyPhase) begin
          code_next[a] = CODE_OVERLOAD_PRE;
        end else if (posInvalid_next[a]) begin
          code_next[a] = CODE_POS_INVALID;
        end else if (reject_reg[a]) begin
          code_next[a] = CODE_SETTING_REJECT;
        end else if (hostSync2_reg.powerOn & hostSync2_reg.detach[a]) begin
          code_next[a] = CODE_AXIS_DETACH;
        end else if (hostSync2_reg.powerOn & hostSync2_reg.estop) begin
          code_next[a] = CODE_HOST_ESTOP;
        end else if (sharedFaults.supplyWarnValid) begin
          code_next[a] = CODE_SUPPLY_WARN
                         | {6'h00, sharedFaults.supplyWarnIdx};
        end
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      alarmActive  <= '0;
      servoOffCmd  <= '0;
      absLoadBlock <= '0;
      absInitReq   <= '0;
      for (int a = 0; a < NUM_AXES; a++) begin
        displayCode[a] <= CODE_NONE;
      end
    end else if (clkEn) begin
      alarmActive  <= alarm_next;
      // Coasting stop; the outer sequence must remove power
      servoOffCmd  <= alarm_next;
      absLoadBlock <= posUnstable_reg;
      absInitReq   <= posInvalid_next;
      for (int a = 0; a < NUM_AXES; a++) begin
        displayCode[a] <= code_next[a];
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_impact_sets: assert property (
    clkEn && axisFaults[0].impactTwo && phServo[0] |=> impact_reg[0])
    else $error("impact alarm not latched");
  a_impact_holds: assert property (
    impact_reg[0] && !resetEdge && !powerDown |=> impact_reg[0])
    else $error("impact alarm dropped without host reset");
  a_link_holds: assert property (
    linkLoss_reg && !powerDown |=> linkLoss_reg)
    else $error("link loss cleared without power cycle");
  a_timeout_sticky: assert property (
    swTimeout_reg |=> swTimeout_reg)
    else $error("timeout alarm released");
  a_startup_phase: assert property (
    clkEn && !phHost && !scaleStart_reg[0] |=> !scaleStart_reg[0])
    else $error("startup warning set outside its phase");
  a_param_keep: assert property (
    clkEn && paramWrEn && !paramWrAxis && paramWrData > paramMax
    |=> paramValue[0] == $past(paramValue[0]))
    else $error("rejected setting was stored");
  a_overload_wait: assert property (
    overload_reg[1] && !loadLow && !powerDown |=> overload_reg[1])
    else $error("overload released above reset load");
  a_alarm_first: assert property (
    alarmActive[0] |-> displayCode[0] >= CODE_OVERLOAD_ONE
                       && displayCode[0] < CODE_SCALE_STARTUP)
    else $error("alarm shown with non-alarm code");
  a_servo_off: assert property (
    clkEn && impact_reg[0] |=> servoOffCmd[0] && alarmActive[0])
    else $error("servo not turned off on alarm");
  // A host power drop may release the latch one cycle later
  a_load_block: assert property (
    clkEn && posUnstable_reg[1] && !powerDown
    |=> absLoadBlock[1] ##1 absLoadBlock[1])
    else $error("counter load not blocked");

  c_impact: cover property (clkEn && impact_reg[0] ##1 resetEdge);
  c_link: cover property (linkLoss_reg ##1 powerDown);
  c_reject: cover property (reject_reg[0]);
  c_estop: cover property (displayCode[0] == CODE_HOST_ESTOP);
endmodule // sawm_alarm_manager

// *** sim/sawm_host_model.sv ***
// Host controller side: drives the command levels only
module sawm_host_model
  import sawm_pkg::*;
(
  input  wire logic             clk,
  output sawm_pkg::sawm_host_s  hostPins
);
  timeunit 1ns;
  timeprecision 1ps;

  initial hostPins = '0;

  // Levels change just after the edge and stay until the next command
  task automatic drive(input logic pw, es, rd,
                       input logic [1:0] sv, dt);
    @(posedge clk);
    hostPins <= '{powerOn: pw, reset: 1'b0, estop: es, ready: rd,
                  servoOn: sv, detach: dt};
  endtask

  // Held several edges so the synchronised edge cannot be missed
  task automatic pulse_reset();
    @(posedge clk);
    hostPins.reset <= 1'b1;
    repeat (4) @(posedge clk);
    hostPins.reset <= 1'b0;
  endtask

  // Outer sequence drops power after an alarm before restarting
  task automatic power_cycle();
    @(posedge clk);
    hostPins.powerOn <= 1'b0;
    hostPins.servoOn <= 2'b00;
    repeat (4) @(posedge clk);
  endtask
endmodule // sawm_host_model

// *** sim/test_servo_alarm_warning_manager.sv ***
module test_servo_alarm_warning_manager
  import sawm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [15:0] P_MIN = 16'h0010;
  localparam logic [15:0] P_MAX = 16'h0100;

  typedef struct packed {
    logic [7:0]  c0;
    logic [7:0]  c1;
    logic [1:0]  al;
    logic [1:0]  so;
    logic        ph;
    logic [15:0] p0;
    logic [15:0] p1;
    logic [1:0]  lb;
    logic [1:0]  ir;
  } sawm_note_s;

  logic               clk;
  logic               sysRst;
  logic               clkEn;
  logic [1:0]         absLoadBlock;
  logic [1:0]         absInitReq;
  logic [1:0]         expLb;
  logic [1:0]         expIr;
  sawm_host_s         hostPins;
  sawm_axis_fault_s   axisFaults [NUM_AXES];
  sawm_shared_fault_s sharedFaults;
  logic [15:0]        olAccum;
  logic [15:0]        olTripLevel;
  logic [7:0]         loadMonPct;
  logic               paramWrEn;
  logic               paramWrAxis;
  logic [15:0]        paramWrData;
  logic [7:0]         displayCode [NUM_AXES];
  logic [1:0]         alarmActive;
  logic [1:0]         servoOffCmd;
  logic [15:0]        paramValue [NUM_AXES];
  logic               phaseDrivePowerOn;
  logic [15:0]        expP [NUM_AXES];
  logic               expPh;
  sawm_note_s         noteQ [$];
  sawm_note_s         nt;
  sawm_note_s         got;
  integer             nErrors;
  integer             checksDone;
  integer             seed = 32'h7353;
  int                 bitTab [6] = '{7, 6, 4, 2, 1, 0};
  logic [7:0]         codeTab [6] = '{CODE_FRAME_RECV, CODE_FRAME_FORMAT,
    CODE_SCALE_DEVIATE, CODE_TURN_COUNTER, CODE_CELL_LOW, CODE_POS_INVALID};

  initial clk = 1'b0;
  always #5 clk = ~clk;

  sawm_host_model host_u (.clk(clk), .hostPins(hostPins));

  sawm_alarm_manager dut_u (
    .clk(clk), .clkEn(clkEn), .sys_rst(sysRst), .hostPins(hostPins),
    .axisFaults(axisFaults), .sharedFaults(sharedFaults),
    .olAccum(olAccum), .olTripLevel(olTripLevel), .loadMonPct(loadMonPct),
    .paramWrEn(paramWrEn), .paramWrAxis(paramWrAxis),
    .paramWrData(paramWrData), .paramMin(P_MIN), .paramMax(P_MAX),
    .displayCode(displayCode), .alarmActive(alarmActive),
    .servoOffCmd(servoOffCmd), .absLoadBlock(absLoadBlock),
    .absInitReq(absInitReq),
    .paramValue(paramValue), .phaseDrivePowerOn(phaseDrivePowerOn));

  function automatic logic alm(input logic [7:0] e);
    return (e != 8'h00) && (e < 8'h90);
  endfunction

  // Settle covers the 3-edge host path and the 2-edge latch path
  task automatic chk(input logic [7:0] e0, e1);
    repeat (6) @(posedge clk);
    noteQ.push_back('{e0, e1, {alm(e1), alm(e0)}, {alm(e1), alm(e0)},
                      expPh, expP[0], expP[1], expLb, expIr});
    // Return on a rising edge so the next stimulus lands on one
    @(posedge clk);
  endtask

  task automatic af(input int ax, input int b, input logic v);
    @(posedge clk);
    axisFaults[ax][b] <= v;
  endtask

  task automatic wr(input logic ax, input logic [15:0] d);
    @(posedge clk);
    paramWrEn <= 1'b1;
    paramWrAxis <= ax;
    paramWrData <= d;
    @(posedge clk);
    paramWrEn <= 1'b0;
    if (d >= P_MIN && d <= P_MAX)
      expP[ax] = d;
  endtask

  task automatic close_out();
    if (nErrors == 0 && checksDone > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(negedge clk) begin
    if (noteQ.size() > 0) begin
      nt = noteQ.pop_front();
      got = '{displayCode[0], displayCode[1], alarmActive, servoOffCmd,
              phaseDrivePowerOn, paramValue[0], paramValue[1],
              absLoadBlock, absInitReq};
      checksDone++;
      if (got !== nt) begin
        nErrors++;
        $display("BAD t=%0t got=%h exp=%h", $time, got, nt);
      end
    end
  end

  initial begin
    #100us;
    nErrors++;
    close_out();
  end

  initial begin
    nErrors = 0;
    checksDone = 0;
    expPh = 1'b1;
    expP = '{16'h0000, 16'h0000};
    expLb = 2'b00;
    expIr = 2'b00;
    clkEn = 1'b1;
    sysRst = 1'b1;
    axisFaults = '{default: '0};
    sharedFaults = '0;
    olAccum = 16'h0000;
    olTripLevel = 16'h0064;
    loadMonPct = 8'h00;
    paramWrEn = 1'b0;
    paramWrAxis = 1'b0;
    paramWrData = 16'h0000;
    repeat (5) @(posedge clk);
    sysRst <= 1'b0;
    chk(CODE_NONE, CODE_NONE);
    host_u.drive(1'b1, 1'b1, 1'b0, 2'b00, 2'b00);
    expPh = 1'b0;
    chk(CODE_HOST_ESTOP, CODE_HOST_ESTOP);
    af(0, 10, 1'b1);
    chk(CODE_HOST_ESTOP, CODE_HOST_ESTOP);
    af(0, 10, 1'b0);
    wr(1'b0, P_MIN + 16'($unsigned($random(seed)) % 200));
    wr(1'b0, P_MAX + 16'h0001 + 16'($unsigned($random(seed)) % 64));
    chk(CODE_SETTING_REJECT, CODE_HOST_ESTOP);
    wr(1'b1, P_MAX);
    wr(1'b0, P_MIN);
    chk(CODE_HOST_ESTOP, CODE_HOST_ESTOP);
    af(0, 8, 1'b1);
    af(0, 8, 1'b0);
    chk(CODE_SCALE_STARTUP, CODE_HOST_ESTOP);
    for (int i = 0; i < 6; i++) begin
      af(1, bitTab[i], 1'b1);
      expIr = {i == 5, 1'b0};
      chk(CODE_SCALE_STARTUP, codeTab[i]);
      af(1, bitTab[i], 1'b0);
      expIr = 2'b00;
      chk(CODE_SCALE_STARTUP, CODE_HOST_ESTOP);
    end
    host_u.drive(1'b1, 1'b0, 1'b0, 2'b11, 2'b00);
    chk(CODE_SCALE_STARTUP, CODE_NONE);
    af(0, 10, 1'b1);
    af(1, 10, 1'b1);
    af(0, 10, 1'b0);
    af(1, 10, 1'b0);
    chk(CODE_IMPACT_TWO, CODE_IMPACT_TWO);
    host_u.pulse_reset();
    chk(CODE_SCALE_STARTUP, CODE_NONE);
    loadMonPct <= 8'h3c;
    af(1, 9, 1'b1);
    af(1, 9, 1'b0);
    host_u.pulse_reset();
    chk(CODE_SCALE_STARTUP, CODE_OVERLOAD_ONE);
    loadMonPct <= 8'h28;
    host_u.pulse_reset();
    chk(CODE_SCALE_STARTUP, CODE_NONE);
    olAccum <= 16'h0050;
    chk(CODE_SCALE_STARTUP, CODE_OVERLOAD_PRE);
    olAccum <= 16'h004f;
    chk(CODE_SCALE_STARTUP, CODE_NONE);
    for (int i = 0; i < 32; i++) begin
      sharedFaults.supplyErrValid <= 1'b1;
      sharedFaults.supplyErrIdx <= 5'(i);
      chk(CODE_SUPPLY_ERR + 8'(i), CODE_SUPPLY_ERR + 8'(i));
    end
    sharedFaults.supplyErrValid <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      sharedFaults.supplyWarnValid <= 1'b1;
      sharedFaults.supplyWarnIdx <= 2'(i);
      chk(CODE_SCALE_STARTUP, CODE_SUPPLY_WARN + 8'(i));
    end
    sharedFaults.supplyWarnValid <= 1'b0;
    af(1, 5, 1'b1);
    af(1, 5, 1'b0);
    expLb = 2'b10;
    chk(CODE_SCALE_STARTUP, CODE_POS_UNSTABLE);
    sharedFaults.supplyLinkLoss <= 1'b1;
    sharedFaults.softwareTimeout <= 1'b1;
    @(posedge clk);
    sharedFaults.supplyLinkLoss <= 1'b0;
    sharedFaults.softwareTimeout <= 1'b0;
    chk(CODE_SUPPLY_LINK, CODE_SUPPLY_LINK);
    host_u.power_cycle();
    expLb = 2'b00;
    chk(CODE_SW_TIMEOUT, CODE_SW_TIMEOUT);
    sysRst <= 1'b1;
    repeat (2) @(posedge clk);
    sysRst <= 1'b0;
    expPh = 1'b1;
    expP = '{16'h0000, 16'h0000};
    chk(CODE_NONE, CODE_NONE);
    host_u.drive(1'b1, 1'b0, 1'b1, 2'b00, 2'b01);
    expPh = 1'b0;
    chk(CODE_AXIS_DETACH, CODE_NONE);
    host_u.drive(1'b1, 1'b1, 1'b1, 2'b00, 2'b01);
    chk(CODE_AXIS_DETACH, CODE_HOST_ESTOP);
    // Frozen enable must hide a new fault until released
    clkEn <= 1'b0;
    af(0, 7, 1'b1);
    chk(CODE_AXIS_DETACH, CODE_HOST_ESTOP);
    clkEn <= 1'b1;
    chk(CODE_FRAME_RECV, CODE_HOST_ESTOP);
    close_out();
  end
endmodule // test_servo_alarm_warning_manager
